// >>> rtl/serial_reg_pkg.sv
// shared constants and carrier types for the serial register write decoder
package serial_reg_pkg;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
  localparam logic [CNT_W-1:0] FRAME_DONE = 5'h10;
  localparam int WE_POS = 15;
  localparam int SEL_HI_POS = 14;
  localparam int SEL_LO_POS = 13;
  localparam int MAIN_MSB = 12;
  localparam int MAIN_LSB = 1;
  localparam int NARROW_MSB = 12;
  localparam int NARROW_LSB = 5;
  // idle levels of the pins {data, select, clock}; the clock idles high
  localparam logic [2:0] PIN_IDLE = 3'h3;

  // register widths and power-up values
  localparam int MAIN_W = 12;
  localparam int NARROW_W = 8;
  localparam logic [MAIN_W-1:0] MAIN_RST = 12'h000;
  localparam logic [NARROW_W-1:0] NARROW_RST = 8'h00;

  // target select codes
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_RANGE1 = 2'h1;
  localparam logic [1:0] SEL_RANGE2 = 2'h2;
  localparam logic [1:0] SEL_SEQ = 2'h3;

  // fields of the main control register used by the output coder and the status word
  localparam int CODING_POS = 4;
  localparam int MODE0_POS = 7;

  // output coding
  localparam int SAMPLE_W = 13;
  localparam logic [SAMPLE_W-1:0] PSEUDO_OFFSET = 13'h1000;

  // avalon slave map, byte addresses
  localparam int AV_ADDR_W = 5;
  localparam logic [AV_ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [AV_ADDR_W-1:0] OFS_MAIN = 5'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_RANGE1 = 5'h0c;
  localparam logic [AV_ADDR_W-1:0] OFS_RANGE2 = 5'h10;
  localparam logic [AV_ADDR_W-1:0] OFS_SEQ = 5'h14;
  localparam logic [AV_ADDR_W-1:0] OFS_SAMPLE = 5'h18;
  localparam logic [AV_ADDR_W-1:0] OFS_CODE = 5'h1c;

  // software control bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CLEAR = 1;
  localparam logic CTL_ENABLE_RST = 1'b1;
  localparam int STAT_CNT_W = 8;

  // avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [AV_ADDR_W-1:0] address;
    logic [31:0] writeData;
    logic [3:0] byteEnable;
  } av_req_t;

  // the four configuration registers
  typedef struct packed {
    logic [MAIN_W-1:0] mainCtrl;
    logic [NARROW_W-1:0] range1;
    logic [NARROW_W-1:0] range2;
    logic [NARROW_W-1:0] seq;
  } cfg_t;

endpackage

// >>> rtl/sync_2ff.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= INIT;
      sync <= INIT;
    end else begin
      meta_r <= async;
      sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/pseudo_diff_coder.sv
// result coder: twos complement or straight binary from a level above ground
`timescale 1ns/1ns
`default_nettype none
module pseudo_diff_coder
  import serial_reg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level above pseudo ground, 0 is ground, all ones is full amplitude
  input wire logic [SAMPLE_W-1:0] level,
  input wire logic straightBin,
  // coded result
  output logic [SAMPLE_W-1:0] code
);

  logic [SAMPLE_W-1:0] twosComp;

  // ground maps to the most negative code, full scale to the most positive
  assign twosComp = level - PSEUDO_OFFSET;

  // register the coded result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      code <= '0;
    end else begin
      code <= straightBin ? level : twosComp;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/serial_register_write_decoder.sv
// serial frame decoder that loads four configuration registers, write-only over the link and read back over avalon
`timescale 1ns/1ns
`default_nettype none
// Function
// - four configuration registers, not readable over link
// - a frame is sixteen serial clocks, later clocks dropped
// - first bits: write enable, upper, lower select
// - write enable low: frame ignored, nothing changes; the code still counts the frame in ignCnt_r
// - write enable high: load into selected register
// - select 00 loads twelve bits into main
// - select 01 loads eight bits into range1
// - select 10 loads eight bits into range2
// - select 11 loads eight bits into sequence
// - pseudo ground codes -4096, full amplitude +4095
// - main register twelve bits, configures next conversion
// - main register clears to zero at power-up
module serial_register_write_decoder
  import serial_reg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial link pins, from outside this clock domain
  input wire logic linkClk,
  input wire logic linkSelN,
  input wire logic linkData,
  // avalon-mm slave
  input wire av_req_t avReq,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  // configuration towards the converter
  output cfg_t cfgOut,
  // conversion result coding
  input wire logic [SAMPLE_W-1:0] convLevel,
  output logic [SAMPLE_W-1:0] convCode
);

  // synchronised pins
  logic [2:0] pinSync;
  logic clkS;
  logic selNS;
  logic dataS;
  logic clkD_r;
  logic clkFall;

  // frame state
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0] bitCnt_r;
  logic [FRAME_BITS-1:0] frameWord;
  logic lastBit;
  logic frameDone;
  logic frameShort;
  logic wrEnBit;
  logic [1:0] selBits;
  logic doWrite;
  logic doIgnore;
  logic bitTake;
  logic [CNT_W-1:0] bitCnt_nxt;

  // configuration registers
  cfg_t cfg_r;
  cfg_t cfg_nxt;

  // software side state
  logic enable_r;
  logic [STAT_CNT_W-1:0] wrCnt_r;
  logic [STAT_CNT_W-1:0] ignCnt_r;
  logic [STAT_CNT_W-1:0] shortCnt_r;
  logic [STAT_CNT_W-1:0] wrCnt_nxt;
  logic [STAT_CNT_W-1:0] ignCnt_nxt;
  logic [STAT_CNT_W-1:0] shortCnt_nxt;
  logic [1:0] lastSel_r;
  logic [SAMPLE_W-1:0] level_r;
  logic [SAMPLE_W-1:0] codeOut;

  // bus decode
  logic avReq_w;
  logic avAccept;
  logic avWr;
  logic hitCtrl;
  logic hitSample;
  logic clearCnt;
  logic [31:0] statusWord;
  logic [31:0] rdMux;
  logic pseudoMode;
  logic ctrlLane0;
  logic rdCapture;
  logic avWait_nxt;
  logic frameBusy;

  // pins pass two flip-flops before anything reads them
  sync_2ff #(
    .WIDTH(3),
    .INIT(PIN_IDLE)
  ) u_pin_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .async({linkData, linkSelN, linkClk}),
    .sync(pinSync)
  );

  assign clkS = pinSync[0];
  assign selNS = pinSync[1];
  assign dataS = pinSync[2];

  // previous serial clock level for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clkD_r <= PIN_IDLE[0]; // idle high, so no false edge after reset
    end else begin
      clkD_r <= clkS;
    end
  end

  // a bit is taken on each falling serial edge while select is low
  assign clkFall = clkD_r & ~clkS & ~selNS;

  // frame decode from the shifted word
  assign frameWord = {shift_r[FRAME_BITS-2:0], dataS};
  assign lastBit = clkFall && (bitCnt_r == LAST_BIT);
  assign frameDone = lastBit && enable_r;
  assign wrEnBit = frameWord[WE_POS];
  assign selBits = {frameWord[SEL_HI_POS], frameWord[SEL_LO_POS]};
  assign doWrite = frameDone && wrEnBit;
  assign doIgnore = frameDone && !wrEnBit;
  assign frameShort = selNS && (bitCnt_r != '0) && (bitCnt_r != FRAME_DONE);

  // a bit counts only until sixteen have been taken
  assign bitTake = clkFall && (bitCnt_r != FRAME_DONE);
  assign bitCnt_nxt = bitCnt_r + 1'b1;

  // bit counter and shifter; extra clocks after sixteen are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bitCnt_r <= '0;
      shift_r <= '0;
    end else if (selNS) begin
      bitCnt_r <= '0;
    end else if (bitTake) begin
      bitCnt_r <= bitCnt_nxt;
      shift_r <= frameWord;
    end
  end

  // next value of the configuration registers
  always_comb begin
    cfg_nxt = cfg_r;
    if (doWrite) begin
      unique case (selBits)
        SEL_MAIN: begin
          cfg_nxt.mainCtrl = frameWord[MAIN_MSB:MAIN_LSB];
        end
        SEL_RANGE1: begin
          cfg_nxt.range1 = frameWord[NARROW_MSB:NARROW_LSB];
        end
        SEL_RANGE2: begin
          cfg_nxt.range2 = frameWord[NARROW_MSB:NARROW_LSB];
        end
        SEL_SEQ: begin
          cfg_nxt.seq = frameWord[NARROW_MSB:NARROW_LSB];
        end
      endcase
    end
  end

  // configuration registers, cleared at power-up
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_r.mainCtrl <= MAIN_RST;
      cfg_r.range1 <= NARROW_RST;
      cfg_r.range2 <= NARROW_RST;
      cfg_r.seq <= NARROW_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // configuration drives the converter straight from flops
  assign cfgOut = cfg_r;

  // avalon decode
  assign avReq_w = avReq.read | avReq.write;
  assign avAccept = avReq_w & ~avWaitRequest;
  assign avWr = avAccept & avReq.write;
  assign hitCtrl = avWr && (avReq.address == OFS_CTRL);
  assign hitSample = avWr && (avReq.address == OFS_SAMPLE);
  assign ctrlLane0 = hitCtrl && avReq.byteEnable[0];
  assign clearCnt = ctrlLane0 && avReq.writeData[CTL_CLEAR];
  assign rdCapture = avReq.read && avWaitRequest;
  assign avWait_nxt = !(avReq_w && avWaitRequest);

  // waitrequest drops for one cycle per request
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      avWaitRequest <= 1'b1;
    end else begin
      avWaitRequest <= avWait_nxt;
    end
  end

  // read data is captured in the cycle that waitrequest drops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      avReadData <= '0;
    end else if (rdCapture) begin
      avReadData <= rdMux;
    end
  end

  // software enable; when low whole frames are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      enable_r <= CTL_ENABLE_RST;
    end else if (ctrlLane0) begin
      enable_r <= avReq.writeData[CTL_ENABLE];
    end
  end

  // counter next values; an event in the clearing cycle still counts
  assign wrCnt_nxt = (clearCnt ? '0 : wrCnt_r) + STAT_CNT_W'(doWrite);
  assign ignCnt_nxt = (clearCnt ? '0 : ignCnt_r) + STAT_CNT_W'(doIgnore);
  assign shortCnt_nxt = (clearCnt ? '0 : shortCnt_r)
                        + STAT_CNT_W'(frameShort);

  // frame counters
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wrCnt_r <= '0;
      ignCnt_r <= '0;
      shortCnt_r <= '0;
    end else begin
      wrCnt_r <= wrCnt_nxt;
      ignCnt_r <= ignCnt_nxt;
      shortCnt_r <= shortCnt_nxt;
    end
  end

  // last accepted select pattern
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lastSel_r <= SEL_MAIN;
    end else if (doWrite) begin
      lastSel_r <= selBits;
    end
  end

  // level to code, written by software
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      level_r <= '0;
    end else if (hitSample) begin
      if (avReq.byteEnable[0]) begin
        level_r[7:0] <= avReq.writeData[7:0];
      end
      if (avReq.byteEnable[1]) begin
        level_r[SAMPLE_W-1:8] <= avReq.writeData[SAMPLE_W-1:8];
      end
    end
  end

  // coding follows the main register; pseudo mode only reported
  assign pseudoMode = cfg_r.mainCtrl[MODE0_POS];

  pseudo_diff_coder u_coder (
    .clk(ref_clk),
    .rstn(rstn),
    .level(convLevel),
    .straightBin(cfg_r.mainCtrl[CODING_POS]),
    .code(convCode)
  );

  pseudo_diff_coder u_sw_coder (
    .clk(ref_clk),
    .rstn(rstn),
    .level(level_r),
    .straightBin(cfg_r.mainCtrl[CODING_POS]),
    .code(codeOut)
  );

  // status word
  assign frameBusy = (bitCnt_r != '0);
  assign statusWord = {4'h0, pseudoMode, frameBusy, lastSel_r,
                       shortCnt_r, ignCnt_r, wrCnt_r};

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    unique case (avReq.address)
      OFS_CTRL: rdMux = {31'h0000_0000, enable_r};
      OFS_STATUS: rdMux = statusWord;
      OFS_MAIN: rdMux = {20'h0_0000, cfg_r.mainCtrl};
      OFS_RANGE1: rdMux = {24'h00_0000, cfg_r.range1};
      OFS_RANGE2: rdMux = {24'h00_0000, cfg_r.range2};
      OFS_SEQ: rdMux = {24'h00_0000, cfg_r.seq};
      OFS_SAMPLE: rdMux = {19'h0_0000, level_r};
      OFS_CODE: rdMux = {19'h0_0000, codeOut};
      default: rdMux = '0;
    endcase
  end

endmodule
`default_nettype wire

// >>> testbench/serial_reg_sva.sv
// port checker for the serial register write decoder
`timescale 1ns/1ns
`default_nettype none
module serial_reg_sva
  import serial_reg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link, bus and result pins
  input wire logic linkSelN,
  input wire av_req_t avReq,
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest,
  input wire cfg_t cfgOut,
  input wire logic [SAMPLE_W-1:0] convLevel,
  input wire logic [SAMPLE_W-1:0] convCode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // request seen and current coding mode
  wire logic reqAny = avReq.read | avReq.write;
  wire logic coding = cfgOut.mainCtrl[CODING_POS];
  // bus answers
  property p_wait_one;
    !avWaitRequest |=> avWaitRequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");
  property p_wait_cause;
    !avWaitRequest |-> $past(reqAny);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray answer");
  property p_rdata;
    $changed(avReadData) |-> !avWaitRequest && avReq.read;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  // result coding, one cycle late
  property p_code;
    rstn |=> convCode == ($past(coding) ? $past(convLevel)
                          : $past(convLevel) - PSEUDO_OFFSET);
  endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_ground;
    rstn && convLevel == 13'h0000 && !coding |=> convCode == 13'h1000;
  endproperty
  a_ground: assert property (p_ground) else $error("ground");
  property p_full;
    rstn && convLevel == 13'h1fff && !coding |=> convCode == 13'h0fff;
  endproperty
  a_full: assert property (p_full) else $error("full scale");
  // a frame loads one register at most, and none while idle
  property p_one_field;
    $changed(cfgOut) |-> $onehot({$changed(cfgOut.mainCtrl),
      $changed(cfgOut.range1), $changed(cfgOut.range2),
      $changed(cfgOut.seq)});
  endproperty
  a_one_field: assert property (p_one_field) else $error("fields");
  property p_idle;
    linkSelN [*8] |=> $stable(cfgOut);
  endproperty
  a_idle: assert property (p_idle) else $error("idle change");
  c_main: cover property ($changed(cfgOut.mainCtrl));
  c_read: cover property (!avWaitRequest && avReq.read);
  c_straight: cover property (coding && convLevel != 13'h0000);
endmodule
bind serial_register_write_decoder serial_reg_sva u_sva (.ref_clk, .rstn,
  .linkSelN, .avReq, .avReadData, .avWaitRequest, .cfgOut, .convLevel,
  .convCode);
`default_nettype wire

// >>> testbench/serial_host_model.sv
// serial master model that shifts frames into the device
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  // link pins towards the device
  output logic linkClk,
  output logic linkSelN,
  output logic linkData
);
  // clock idles high outside frames
  initial begin
    linkClk = 1'b1;
    linkSelN = 1'b1;
    linkData = 1'b0;
  end
  // n clocks, msb first, data moves while the clock is high
  task automatic send(input logic [15:0] f, input int n);
    #1; // pin edges stay clear of the system clock edge
    linkSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      linkData = f[4'(15 - i)];
      #80 linkClk = 1'b0;
      #80 linkClk = 1'b1;
    end
    linkData = ~linkData; // released line shows no stale bit
    #80 linkSelN = 1'b1;
    #239;
  endtask
endmodule
`default_nettype wire

// >>> testbench/serial_register_write_decoder_tb.sv
// self-checking bench for the serial register write decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin \
  failures++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module serial_register_write_decoder_tb
  import serial_reg_pkg::*;
();
  logic ref_clk, rstn, linkClk, linkSelN, linkData, avWaitRequest;
  av_req_t avReq;
  logic [31:0] avReadData, rd;
  cfg_t cfgOut, exp;
  logic [SAMPLE_W-1:0] convLevel, convCode, lvl;
  logic [SAMPLE_W-1:0] lv [3] = '{13'h0000, 13'h1fff, 13'h0800};
  int failures = 0;
  int testsRun = 0;
  serial_register_write_decoder u_dut (.ref_clk, .rstn, .linkClk, .linkSelN,
    .linkData, .avReq, .avReadData, .avWaitRequest, .cfgOut, .convLevel,
    .convCode);
  serial_host_model u_host (.linkClk, .linkSelN, .linkData);
  // system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [AV_ADDR_W-1:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avReq <= '{!wr, wr, a, d, 4'hf};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 100);
    rd = avReadData;
    avReq <= '0;
    if (n >= 100) begin
      failures++;
      final_report();
    end
  endtask
  // every target takes its own field, trailing bits dropped
  task automatic t_targets();
    logic [15:0] f;
    logic [11:0] fv;
    for (int s = 0; s < 4; s++) begin
      f = {1'b1, 2'(s), 13'h1a5b ^ (13'(s) * 13'h0123)};
      u_host.send(f, FRAME_BITS);
      fv = {4'h0, f[NARROW_MSB:NARROW_LSB]};
      case (2'(s))
        SEL_MAIN: begin
          exp.mainCtrl = f[MAIN_MSB:MAIN_LSB];
          fv = exp.mainCtrl;
        end
        SEL_RANGE1: exp.range1 = fv[7:0];
        SEL_RANGE2: exp.range2 = fv[7:0];
        default: exp.seq = fv[7:0];
      endcase
      `CHK("cfg", exp, cfgOut)
      av(1'b0, OFS_MAIN + 5'(s * 4), 32'h0);
      `CHK("view", {20'h0, fv}, rd)
    end
    $display("targets done");
  endtask
  // write bit low, short frame, decoder disabled, long frame
  task automatic t_refuse();
    u_host.send(16'h7fff, FRAME_BITS);
    `CHK("ignored", exp, cfgOut)
    u_host.send(16'h8fff, 10);
    `CHK("short", exp, cfgOut)
    av(1'b1, OFS_CTRL, 32'h0);
    u_host.send(16'h8fff, FRAME_BITS);
    `CHK("disabled", exp, cfgOut)
    av(1'b1, OFS_CTRL, 32'h1);
    av(1'b0, OFS_STATUS, 32'h0);
    `CHK("counts", 24'h01_0104, rd[23:0])
    u_host.send(16'hb3c5, 18);
    exp.range1 = 8'h9e;
    `CHK("long", exp, cfgOut)
    $display("refuse done");
  endtask
  // result coding in both modes, at the port and over the bus
  task automatic t_code();
    for (int c = 0; c < 2; c++) begin
      u_host.send({3'b100, 7'h00, 1'(c), 5'h00}, FRAME_BITS);
      exp.mainCtrl = {7'h00, 1'(c), 4'h0};
      foreach (lv[i]) begin
        @(posedge ref_clk);
        convLevel <= lv[i];
        lvl = c ? lv[i] : lv[i] - PSEUDO_OFFSET;
        repeat (2) @(posedge ref_clk);
        `CHK("code", lvl, convCode)
        av(1'b1, OFS_SAMPLE, {19'h0, lv[i]});
        av(1'b0, OFS_CODE, 32'h0);
        `CHK("bus code", lvl, rd[SAMPLE_W-1:0])
      end
    end
    `CHK("cfg", exp, cfgOut)
    $display("code done");
  endtask
  // reset in mid run clears the four configuration registers
  task automatic t_rerst();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    exp = '0;
    `CHK("cfg", exp, cfgOut)
    $display("reset done");
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    avReq = '0;
    convLevel = '0;
    exp = '0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("cfg", exp, cfgOut)
    t_targets();
    t_refuse();
    t_code();
    t_rerst();
    final_report();
  end
endmodule
`default_nettype wire
